// ===== core/psr_map.svh
// constants for the pressure sensor serial readout
`ifndef PSR_MAP_SVH
`define PSR_MAP_SVH
`define PSR_CLK_NS       10
`define PSR_SS_MIN_NS    8000
`define PSR_SS_MIN_CYC   ((`PSR_SS_MIN_NS + `PSR_CLK_NS - 1) / `PSR_CLK_NS)
`define PSR_CNT_W        10
`define PSR_FRAME_BITS   6'h20
`define PSR_ST_NORMAL    2'h0
`define PSR_ST_CMD       2'h1
`define PSR_ST_STALE     2'h2
`define PSR_ST_DIAG      2'h3
`define PSR_PAD          5'h00
`define PSR_FIFO_DEPTH   16
`define PSR_ST_HI        31
`define PSR_ST_LO        30
`endif

// ===== core/psr_pkg.sv
// types shared by the pressure sensor serial readout
package psr_pkg;
  // one measurement as handed in by the conversion logic
  typedef struct packed {
    logic [1:0]  status;
    logic [13:0] press;
    logic [10:0] temp;
  } psr_meas_t;

  // the 32-bit word shifted out, msb first
  typedef struct packed {
    logic [1:0]  status;
    logic [13:0] press;
    logic [10:0] temp;
    logic [4:0]  pad;
  } psr_frame_t;

  // control states on the system clock
  typedef enum logic [1:0] {
    PSR_IDLE = 2'b01,
    PSR_SEL  = 2'b10
  } psr_state_t;
endpackage

// ===== core/psr_spi_readout.sv
// fifo and serial readout port of the pressure sensor
`timescale 1ns/1ns
`include "psr_map.svh"

// ----------------------------------------
// measurement fifo
// ----------------------------------------
module psr_fifo #(
  parameter int W = 27,
  parameter int D = `PSR_FIFO_DEPTH
) (
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  // honest full and empty from the fill count
  assign in_ready  = (count != (AW+1)'(D));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];

  // storage
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
      count  <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // fill level stays within depth, a full fifo refuses, the head waits
  a_fifo_bound: assert property (@(posedge mclk) disable iff (!rstn) // R9
    count <= (AW+1)'(D))
    else $error("fifo fill level past depth");

  a_fifo_full: assert property (@(posedge mclk) disable iff (!rstn) // R9
    count == (AW+1)'(D) |-> !in_ready)
    else $error("full fifo still ready");

  a_fifo_refuse: assert property (@(posedge mclk) disable iff (!rstn) // R9
    in_valid && !in_ready && !out_ready |=> count == $past(count))
    else $error("word taken while full");

  a_fifo_hold: assert property (@(posedge mclk) disable iff (!rstn) // R9
    out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("fifo head changed before pop");
endmodule // psr_fifo

// What this block does
// (R1) every reading carries status: 00 normal, 01 command, 10 stale, 11 diagnostic
// (R2) mode 0: clock idles low, master samples rising, sensor changes on falling
// (R3) master drives clock, mosi and select; sensor drives only miso
// (R4) up to four bytes per selection, msb first, no command phase
// (R5) byte one top two bits status, then pressure; temperature in bytes three, four
// (R6) master may stop after any byte; rest of frame is dropped
// (R7) select low at least 8 us then high starts a new measurement
// (R8) on select, first bit is presented before the first clock edge
// (R9) pressure count passes through linear, unaltered, from conversion logic
// (R10) pressure is fourteen bits: byte one low six bits and byte two
// (R11) temperature count passes through unaltered for linear conversion to Celsius
// (R12) byte four low five bits are zero; temperature is eleven bits
// (R13) deselected: miso undriven and clock ignored
module psr_spi_readout (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic              sclk,
  input  wire logic              ss_n,
  input  wire logic              mosi,
  output logic                   miso_out,
  output logic                   miso_oe,
  output logic                   meas_req,
  input  wire logic              in_valid,
  output logic                   in_ready,
  input  wire psr_pkg::psr_meas_t in_data,
  output logic                   stale
);
  // ----------------------------------------
  // system clock side
  // ----------------------------------------
  psr_pkg::psr_state_t state;
  psr_pkg::psr_state_t next_state;
  psr_pkg::psr_frame_t frame;
  psr_pkg::psr_meas_t  fifo_data;
  logic                fifo_valid;
  logic                ss_q1;
  logic                ss_q2;
  logic                ss_q3;
  logic [`PSR_CNT_W-1:0] low_cnt;
  logic [5:0]          bit_cnt;

  localparam logic [`PSR_CNT_W-1:0] SS_MIN = `PSR_CNT_W'(`PSR_SS_MIN_CYC);

  wire ss_fall  = ss_q3 && !ss_q2;
  wire ss_rise  = !ss_q3 && ss_q2;
  wire long_low = (low_cnt >= SS_MIN);
  wire trigger  = ss_rise && long_low;
  wire pop      = (state == psr_pkg::PSR_IDLE) && fifo_valid && ss_q2;
  wire diag     = (frame.status == `PSR_ST_DIAG);

  psr_fifo #(.W($bits(psr_pkg::psr_meas_t)), .D(`PSR_FIFO_DEPTH)) u_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .in_valid  (in_valid),
    .in_ready  (in_ready),
    .in_data   (in_data),
    .out_valid (fifo_valid),
    .out_ready (pop),
    .out_data  (fifo_data)
  );

  // select pin through two flops, third for edges
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ss_q1 <= 1'b1;
      ss_q2 <= 1'b1;
      ss_q3 <= 1'b1;
    end else begin
      ss_q1 <= ss_n;
      ss_q2 <= ss_q1;
      ss_q3 <= ss_q2;
    end
  end

  // idle until select falls, hold frame while selected
  always_comb begin
    next_state = state;
    unique case (state)
      psr_pkg::PSR_IDLE: if (ss_fall) next_state = psr_pkg::PSR_SEL;
      psr_pkg::PSR_SEL:  if (ss_rise) next_state = psr_pkg::PSR_IDLE;
      default:           next_state = psr_pkg::PSR_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state <= psr_pkg::PSR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // low time of select, saturating at the minimum
  always_ff @(posedge mclk) begin
    if (!rstn || ss_q2) begin
      low_cnt <= '0;
    end else if (!long_low) begin
      low_cnt <= low_cnt + 1'b1; // R7
    end
  end

  // long select pulse ending asks for a new measurement
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      meas_req <= 1'b0;
    end else begin
      meas_req <= trigger; // R7
    end
  end

  // frame load from fifo; reread data marked stale unless diagnostic
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      frame <= '{status: `PSR_ST_STALE, press: '0, temp: '0, pad: `PSR_PAD};
      stale <= 1'b1;
    end else if (pop) begin
      frame.status <= fifo_data.status; // R1
      frame.press  <= fifo_data.press;  // R9 R10
      frame.temp   <= fifo_data.temp;   // R11 R12
      frame.pad    <= `PSR_PAD;         // R12
      stale        <= 1'b0;
    end else if (trigger) begin
      stale <= 1'b1;
      if (!diag) begin
        frame.status <= `PSR_ST_STALE; // R1
      end
    end
  end

  // ----------------------------------------
  // link clock side
  // ----------------------------------------
  // bit position moves on falling edges, cleared by deselect
  always_ff @(negedge sclk or posedge ss_n) begin
    if (ss_n) begin
      bit_cnt <= '0; // R6 R13
    end else if (bit_cnt != `PSR_FRAME_BITS) begin
      bit_cnt <= bit_cnt + 1'b1; // R2 R4
    end
  end

  // frame holds still while selected, so it is read across domains;
  // a pop or a stale mark only lands while select is seen high, which
  // keeps the frame quiet from a few mclk cycles after select falls
  wire [31:0] frame_bits = frame;
  wire        in_frame   = (bit_cnt != `PSR_FRAME_BITS);
  wire        cur_bit    = frame_bits[~bit_cnt[4:0]]; // R4 R5 R8

  assign miso_out = in_frame && cur_bit; // R2 R3
  assign miso_oe  = !ss_n;               // R3 R13

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_pop_when_idle: assert property (@(posedge mclk) disable iff (!rstn) // R13
    pop |-> state == psr_pkg::PSR_IDLE && ss_q2)
    else $error("fifo popped while selected");

  a_frame_held: assert property (@(posedge mclk) disable iff (!rstn) // R6
    state == psr_pkg::PSR_SEL && !ss_rise |=> $stable(frame))
    else $error("frame changed while selected");

  a_meas_long: assert property (@(posedge mclk) disable iff (!rstn) // R7
    ss_rise && low_cnt >= SS_MIN |=> meas_req ##1 !meas_req)
    else $error("no measurement after long select");

  a_meas_short: assert property (@(posedge mclk) disable iff (!rstn) // R7
    meas_req |-> $past(ss_rise) && $past(low_cnt) == SS_MIN)
    else $error("measurement without long select");

  a_stale_code: assert property (@(posedge mclk) disable iff (!rstn) // R1
    trigger && !pop && !diag |=> frame.status == `PSR_ST_STALE && stale)
    else $error("reread frame not marked stale");

  a_diag_kept: assert property (@(posedge mclk) disable iff (!rstn) // R1
    trigger && !pop && diag |=> frame.status == `PSR_ST_DIAG)
    else $error("diagnostic status lost");

  a_load_fresh: assert property (@(posedge mclk) disable iff (!rstn) // R10
    pop |=> frame.press == $past(fifo_data.press) && frame.temp == $past(fifo_data.temp) && !stale)
    else $error("frame not loaded from fifo");

  a_pad_zero: assert property (@(posedge mclk) disable iff (!rstn) // R12
    frame.pad == `PSR_PAD)
    else $error("unused bits not zero");

  a_first_bit: assert property (@(posedge sclk) disable iff (ss_n) // R8
    bit_cnt == 6'h00 |-> miso_out == frame.status[1])
    else $error("first bit is not the msb");

  a_frame_end: assert property (@(posedge sclk) disable iff (ss_n) // R4
    bit_cnt == `PSR_FRAME_BITS |-> !miso_out)
    else $error("data past four bytes");

  a_req_pulse: assert property (@(posedge mclk) disable iff (!rstn) // R7
    meas_req |=> !meas_req)
    else $error("measurement request longer than one cycle");

  a_short_no_req: assert property (@(posedge mclk) disable iff (!rstn) // R7
    ss_rise && !long_low |=> !meas_req)
    else $error("measurement after short select");

  a_idle_state: assert property (@(posedge mclk) disable iff (!rstn) // R13
    ss_q2 && ss_q3 |-> state == psr_pkg::PSR_IDLE)
    else $error("not idle while deselected");

  a_sel_state: assert property (@(posedge mclk) disable iff (!rstn) // R8
    !ss_q2 && !ss_q3 |-> state == psr_pkg::PSR_SEL)
    else $error("not selected while select is low");

  // link side: each field sits at its place in the shifted frame
  a_second_bit: assert property (@(posedge sclk) disable iff (ss_n) // R5
    bit_cnt == 6'h01 |-> miso_out == frame.status[0])
    else $error("second bit is not status lsb");

  a_press_msb: assert property (@(posedge sclk) disable iff (ss_n) // R10
    bit_cnt == 6'h02 |-> miso_out == frame.press[13])
    else $error("pressure msb misplaced");

  a_temp_msb: assert property (@(posedge sclk) disable iff (ss_n) // R12
    bit_cnt == 6'h10 |-> miso_out == frame.temp[10])
    else $error("temperature msb misplaced");

  a_pad_shift: assert property (@(posedge sclk) disable iff (ss_n) // R12
    bit_cnt >= 6'h1B && bit_cnt < `PSR_FRAME_BITS |-> !miso_out)
    else $error("unused bits shifted as ones");

  c_long_select: cover property (@(posedge mclk) disable iff (!rstn) trigger);
  c_fifo_pop:    cover property (@(posedge mclk) disable iff (!rstn) pop);
  c_full_read:   cover property (@(posedge sclk) disable iff (ss_n) bit_cnt == 6'h1F);
  c_fifo_full:   cover property (@(posedge mclk) disable iff (!rstn) !in_ready);
  c_diag_kept:   cover property (@(posedge mclk) disable iff (!rstn) trigger && diag);
endmodule // psr_spi_readout

// ===== verification/psr_spi_master.sv
// spi master model that reads frames from the sensor
`timescale 1ns/1ns

// ----------------------------------------
// master model
// ----------------------------------------
module psr_spi_master (
  output logic     sclk,
  output logic     ss_n,
  output logic     mosi,
  input  wire logic miso_out,
  input  wire logic miso_oe,
  output logic     miso
);
  logic last;
  logic tail;

  // released line shows the inverse of the last driven bit, no pull-up
  assign miso = miso_oe ? miso_out : ~last;

  // remember the last bit driven by the sensor
  always @(posedge sclk) begin
    if (miso_oe) last <= miso_out;
  end

  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
    last = 1'b0;
    tail = 1'b0;
  end

  // select, wait, clock nbits msb first, stop the clock, release
  task automatic xfer(input int hold_ns, input int nbits, output logic [31:0] bits);
    bits = 32'h00000000;
    tail = 1'b0;
    #3 ss_n = 1'b0;
    #(hold_ns);
    for (int i = 0; i < nbits; i++) begin
      #24 sclk = 1'b1;
      if (i < 32) bits[31-i] = miso;
      else tail = tail | miso;
      #24 sclk = 1'b0;
      mosi = ~mosi;
    end
    #200 ss_n = 1'b1;
    #2000;
  endtask

  // hold select at a level without clocking
  task automatic hold(input logic v);
    ss_n = v;
  endtask

  // toggle the clock with select released; the sensor must not move
  task automatic spin(input int n);
    for (int i = 0; i < n; i++) begin
      #24 sclk = 1'b1;
      #24 sclk = 1'b0;
    end
  endtask
endmodule // psr_spi_master

// ===== verification/test_psr_spi_readout.sv
// self-checking bench for the pressure sensor serial readout
`timescale 1ns/1ns

// ----------------------------------------
// bench top
// ----------------------------------------
module test_psr_spi_readout;
  logic               mclk, rstn, in_valid, sclk, ss_n, mosi;
  logic               miso_out, miso_oe, miso, meas_req, in_ready, stale;
  psr_pkg::psr_meas_t in_data, w;
  logic [31:0]        got;
  int                 errors, compares, reqs, n;
  integer             seed;

  psr_spi_readout dut (.mclk(mclk), .rstn(rstn), .sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso_out(miso_out),
    .miso_oe(miso_oe), .meas_req(meas_req), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .stale(stale));
  psr_spi_master master (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso_out(miso_out), .miso_oe(miso_oe),
    .miso(miso));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // count measurement requests
  always @(posedge mclk) begin
    if (meas_req === 1'b1) reqs <= reqs + 1;
  end

  // expected frame; a stale frame shows 10 unless diagnostic
  function automatic logic [31:0] exp_frame(input psr_pkg::psr_meas_t m, input logic old);
    logic [1:0] st;
    st = (old && m.status != 2'h3) ? 2'h2 : m.status;
    return {st, m.press, m.temp, 5'h00};
  endfunction

  function automatic psr_pkg::psr_meas_t rnd(input logic [1:0] st);
    logic [31:0] v;
    v = $random(seed);
    return {st, v[24:0]};
  endfunction

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic push(input psr_pkg::psr_meas_t m);
    @(posedge mclk);
    in_valid <= 1'b1;
    in_data  <= m;
    @(posedge mclk);
    in_valid <= 1'b0;
    repeat (8) @(posedge mclk);
  endtask

  task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // cut a hang short
  initial begin
    #500000;
    errors++;
    report_and_stop();
  end

  initial begin
    rstn = 1'b0;
    in_valid = 1'b0;
    in_data = '0;
    seed = 32'h8114BF62;
    errors = 0;
    compares = 0;
    reqs = 0;
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    @(negedge mclk);
    check(32'({stale, in_ready, miso_oe}), 32'h6);
    master.xfer(2500, 32, got);
    check(got, 32'h80000000);
    $display("test reset frame done");
    for (int s = 0; s < 4; s++) begin
      w = rnd(s[1:0]);
      push(w);
      n = reqs;
      master.xfer(2500, 32, got);
      check(got, exp_frame(w, 1'b0));
      check(reqs - n, 0);
      master.xfer(8000, 0, got);
      check(reqs - n, 1);
      check(32'(stale), 32'h1);
      master.xfer(2500, 32, got);
      check(got, exp_frame(w, 1'b1));
    end
    $display("test status codes done");
    w = rnd(2'h0);
    push(w);
    master.xfer(2500, 8, got);
    check(got >> 24, exp_frame(w, 1'b0) >> 24);
    master.spin(8);
    check(32'(miso_oe), 32'h0);
    master.xfer(2500, 34, got);
    check(got, exp_frame(w, 1'b0));
    check(32'(master.tail), 32'h0);
    $display("test early stop done");
    master.hold(1'b0);
    repeat (5) @(posedge mclk);
    for (int i = 0; i < 16; i++) begin
      w = rnd(2'h3);
      in_valid <= 1'b1;
      in_data  <= w;
      @(posedge mclk);
    end
    in_data <= rnd(2'h1);
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    check(32'(in_ready), 32'h0);
    @(posedge mclk);
    in_valid <= 1'b0;
    @(negedge mclk);
    master.hold(1'b1);
    repeat (60) @(posedge mclk);
    @(negedge mclk);
    check(32'(in_ready), 32'h1);
    master.xfer(2500, 32, got);
    check(got, exp_frame(w, 1'b0));
    $display("test fifo fill done");
    report_and_stop();
  end
endmodule // test_psr_spi_readout
